// *** src/pll_synth_pkg.sv ***
// pll_synth_pkg: register map, reset values, timing counts and helpers
// for the clock synthesizer control block.
// Assumes one 10 MHz system clock; all other clocks arrive as sampled pins.
package pll_synth_pkg;

  // system clock and reset pulse timing
  localparam int unsigned CLK_MHZ       = 10;
  localparam int unsigned RST_PULSE_NS  = 10;
  localparam int unsigned RST_PULSE_CYC =
    (RST_PULSE_NS * CLK_MHZ + 999) / 1000;

  // register indices
  localparam logic [3:0] A_CTRL     = 4'h0;
  localparam logic [3:0] A_MULT     = 4'h1;
  localparam logic [3:0] A_PREDIV   = 4'h2;
  localparam logic [3:0] A_POSTDIV  = 4'h3;
  localparam logic [3:0] A_DIV0     = 4'h4;
  localparam logic [3:0] A_DIV1     = 4'h5;
  localparam logic [3:0] A_DIV2     = 4'h6;
  localparam logic [3:0] A_STATUS   = 4'h7;
  localparam logic [3:0] A_IRQ_STAT = 4'h8;
  localparam logic [3:0] A_IRQ_MASK = 4'h9;

  // field positions
  localparam int unsigned CTRL_FB_LSB  = 0;
  localparam int unsigned CTRL_EN_LSB  = 2;
  localparam int unsigned ST_LOCKED    = 0;
  localparam int unsigned ST_CFG_ERR   = 1;
  localparam int unsigned ST_STALLED   = 2;
  localparam int unsigned ST_HELD      = 3;
  localparam int unsigned IRQ_GAINED   = 0;
  localparam int unsigned IRQ_LOST     = 1;
  localparam int unsigned IRQ_CFG      = 2;

  // values after reset
  localparam logic [1:0] RST_FB      = 2'h0;
  localparam logic [2:0] RST_OUT_EN  = 3'h1;
  localparam logic [7:0] RST_MULT    = 8'h01;
  localparam logic [3:0] RST_PREDIV  = 4'h1;
  localparam logic [1:0] RST_POSTDIV = 2'h1;
  localparam logic [7:0] RST_CDIV    = 8'h01;

  // lock detector and output accumulator counts
  localparam logic [3:0]  LOCK_PFD       = 4'h8;
  localparam logic [7:0]  STALL_CYC      = 8'h40;
  localparam logic [7:0]  PER_TOL        = 8'h02;
  localparam logic [20:0] MAX_FB_PRODUCT = 21'h0000FF;
  localparam logic [13:0] ACC_CAP        = 14'h1000;
  localparam logic [13:0] PHASE_SKEW     = 14'h0005;

  typedef enum logic [1:0] {FB_INTERNAL, FB_LOCAL, FB_FABRIC} fb_mode_t;
  typedef enum logic [1:0] {LK_HELD, LK_ACQUIRE, LK_LOCKED} lock_state_t;

  // post-divider code 0..3 stands for 1, 2, 4, 8
  function automatic logic [3:0] post_div_val(input logic [1:0] code);
    post_div_val = 4'h1 << code;
  endfunction

endpackage

// *** src/synth_chan_if.sv ***
// synth_chan_if: controls from the synthesizer core to one output channel
// and the channel's clock back.
// Assumes both ends run on the same system clock.
interface synth_chan_if;
  logic        pfd_tick;
  logic        run;
  logic        aligned;
  logic        skip_delay;
  logic [7:0]  mult;
  logic [11:0] total;
  logic        clk;
  modport ctrl (output pfd_tick, run, aligned, skip_delay, mult, total,
                input clk);
  modport chan (input pfd_tick, run, aligned, skip_delay, mult, total,
                output clk);
endinterface

// *** src/synth_out_channel.sv ***
// synth_out_channel: one synthesized output, a phase accumulator that
// toggles the clock at reference * M / (N * O * C).
// Assumes pfd_tick is a one-cycle pulse on the system clock.
module synth_out_channel (
  input wire logic   ref_clk_in,
  input wire logic   srst_in,
  synth_chan_if.chan ch
);
  typedef struct packed {
    logic [13:0] acc;
    logic        lvl;
    logic        dly;
    logic        out;
  } chan_state_t;

  chan_state_t q;
  chan_state_t d;
  logic [13:0] sum;

  // accumulate 2M per detector tick, drain O*C per toggle
  always_comb begin
    d   = q;
    sum = q.acc;
    if (!ch.run) begin
      d.acc = ch.aligned ? '0 : pll_synth_pkg::PHASE_SKEW;
      d.lvl = 1'b0;
      d.dly = 1'b0;
      d.out = 1'b0;
    end else begin
      if (ch.pfd_tick && q.acc < pll_synth_pkg::ACC_CAP)
        sum = q.acc + {5'h00, ch.mult, 1'b0};
      if (sum >= {2'h0, ch.total}) begin
        sum   = sum - {2'h0, ch.total};
        d.lvl = ~q.lvl;
      end
      d.acc = sum;
      d.dly = d.lvl;
      // fabric feedback removes the insertion stage
      d.out = ch.skip_delay ? d.lvl : q.dly;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in)
      q <= '0;
    else
      q <= d;
  end

  assign ch.clk = q.out;
endmodule

// *** src/pll_clock_synthesizer_ctrl.sv ***
// pll_clock_synthesizer_ctrl: control and status of a clock synthesizer:
// reference select, reset, lock detect, three divided clock outputs.
// Assumes reference, feedback, select and reset pins are asynchronous and
// that software configures it through a plain register port.
module pll_clock_synthesizer_ctrl #(
  parameter int unsigned DW = 16
) (
  input  wire logic          ref_clk_in,
  input  wire logic          srst_in,
  input  wire logic [3:0]    reference_clock_inputs_in,
  input  wire logic [1:0]    reference_source_select_in,
  input  wire logic          synth_reset_low_in,
  input  wire logic          fabric_feedback_clock_in,
  input  wire logic [3:0]    addr_in,
  input  wire logic [DW-1:0] wdata_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  output logic      [DW-1:0] rdata_out,
  output logic               synth_clock_out_0,
  output logic               synth_clock_out_1,
  output logic               synth_clock_out_2,
  output logic               clocks_valid_out,
  output logic               locked_out,
  output logic               irq_out
);
  typedef struct packed {
    // software settings
    logic [1:0]      fb_mode;
    logic [2:0]      out_en;
    logic [7:0]      mult;
    logic [3:0]      prediv;
    logic [1:0]      postdiv;
    logic [2:0][7:0] cdiv;
    // settings in force, taken while held in reset
    logic [1:0]      a_fb;
    logic [2:0]      a_en;
    logic [7:0]      a_mult;
    logic [3:0]      a_prediv;
    logic [1:0]      a_post;
    logic [2:0][7:0] a_cdiv;
    logic            cfg_err;
    // interrupt registers and read data
    logic [2:0]      irq_stat;
    logic [2:0]      irq_mask;
    logic [DW-1:0]   rdata;
    // pin synchronisers
    logic [3:0]      ref_s1;
    logic [3:0]      ref_s2;
    logic [1:0]      sel_s1;
    logic [1:0]      sel_s2;
    logic            rst_s1;
    logic            rst_s2;
    logic            fb_s1;
    logic            fb_s2;
    logic            ref_prev;
    logic            fb_prev;
    // phase detector divider and lock detector
    logic [3:0]      pfd_cnt;
    logic            pfd_tick;
    pll_synth_pkg::lock_state_t lk;
    logic [3:0]      lock_cnt;
    logic [7:0]      gap;
    logic [7:0]      last_per;
    logic            per_ok;
    logic [7:0]      fb_gap;
    logic            fb_seen;
    logic            valid;
  } ctrl_state_t;

  ctrl_state_t q;
  ctrl_state_t d;

  logic        ref_lvl;
  logic        ref_edge;
  logic        fb_edge;
  logic        held;
  logic        stalled;
  logic        mismatch;
  logic        fb_lost;
  logic        cfg_ok;
  logic [7:0]  period;
  logic [7:0]  diff;
  logic [20:0] fb_product;
  logic [2:0]  ev;

  // true when more than one output is switched on
  function automatic logic several_on(input logic [2:0] en);
    several_on = (en[0] & en[1]) | (en[0] & en[2]) | (en[1] & en[2]);
  endfunction

  // output divider C for a register value of C - 1
  function automatic logic [8:0] cdiv_val(input logic [7:0] v);
    cdiv_val = {1'b0, v} + 9'h001;
  endfunction

  // the whole control state as one next-state computation
  always_comb begin
    d       = q;
    d.rdata = '0;
    ev      = 3'h0;

    // two-flop synchronisers for every asynchronous pin
    d.ref_s1 = reference_clock_inputs_in;
    d.ref_s2 = q.ref_s1;
    d.sel_s1 = reference_source_select_in;
    d.sel_s2 = q.sel_s1;
    d.rst_s1 = synth_reset_low_in;
    d.rst_s2 = q.rst_s1;
    d.fb_s1  = fabric_feedback_clock_in;
    d.fb_s2  = q.fb_s1;

    // selected reference and its rising edges
    ref_lvl   = q.ref_s2[q.sel_s2];
    d.ref_prev = ref_lvl;
    ref_edge  = ref_lvl & ~q.ref_prev;
    d.fb_prev = q.fb_s2;
    fb_edge   = q.fb_s2 & ~q.fb_prev;
    held      = ~q.rst_s2;

    // settings check on the software copy
    fb_product = 21'(q.mult) *
                 21'(pll_synth_pkg::post_div_val(q.postdiv)) *
                 21'(cdiv_val(q.cdiv[0]));
    cfg_ok = (q.mult != 8'h00) && (q.prediv != 4'h0);
    if (q.fb_mode > 2'(pll_synth_pkg::FB_FABRIC))
      cfg_ok = 1'b0;
    if (several_on(q.out_en) && q.postdiv == 2'h0)
      cfg_ok = 1'b0;
    if (q.fb_mode != 2'(pll_synth_pkg::FB_INTERNAL) &&
        fb_product > pll_synth_pkg::MAX_FB_PRODUCT)
      cfg_ok = 1'b0;

    // reference period watch: a long gap means a stopped reference
    stalled  = q.gap >= pll_synth_pkg::STALL_CYC;
    period   = (q.gap == 8'hFF) ? q.gap : q.gap + 8'h01;
    diff     = (period > q.last_per) ? period - q.last_per
                                     : q.last_per - period;
    mismatch = ref_edge && q.per_ok && !stalled &&
               diff > pll_synth_pkg::PER_TOL;
    fb_lost  = q.a_fb == 2'(pll_synth_pkg::FB_FABRIC) && !stalled &&
               q.fb_gap >= pll_synth_pkg::STALL_CYC;
    d.gap    = (q.gap == 8'hFF) ? q.gap : q.gap + 8'h01;
    d.fb_gap = (q.fb_gap == 8'hFF) ? q.fb_gap : q.fb_gap + 8'h01;
    if (fb_edge) begin
      d.fb_gap  = 8'h00;
      d.fb_seen = 1'b1;
    end
    if (ref_edge) begin
      d.gap      = 8'h00;
      d.last_per = period;
      d.per_ok   = ~stalled;  // first edge after a stop is discarded
    end

    // register writes
    if (wr_in) begin
      unique case (addr_in)
        pll_synth_pkg::A_CTRL: begin
          d.fb_mode = wdata_in[pll_synth_pkg::CTRL_FB_LSB +: 2];
          d.out_en  = wdata_in[pll_synth_pkg::CTRL_EN_LSB +: 3];
        end
        pll_synth_pkg::A_MULT:     d.mult     = wdata_in[7:0];
        pll_synth_pkg::A_PREDIV:   d.prediv   = wdata_in[3:0];
        pll_synth_pkg::A_POSTDIV:  d.postdiv  = wdata_in[1:0];
        pll_synth_pkg::A_DIV0:     d.cdiv[0]  = wdata_in[7:0];
        pll_synth_pkg::A_DIV1:     d.cdiv[1]  = wdata_in[7:0];
        pll_synth_pkg::A_DIV2:     d.cdiv[2]  = wdata_in[7:0];
        pll_synth_pkg::A_IRQ_STAT: d.irq_stat = q.irq_stat & ~wdata_in[2:0];
        pll_synth_pkg::A_IRQ_MASK: d.irq_mask = wdata_in[2:0];
        default: ;
      endcase
    end

    // phase detector divider and lock state
    d.pfd_tick = 1'b0;
    if (held) begin
      // settings are taken only while held, so a running loop never
      // sees a half-written configuration
      d.a_fb     = q.fb_mode;
      d.a_en     = q.out_en;
      d.a_mult   = q.mult;
      d.a_prediv = q.prediv;
      d.a_post   = q.postdiv;
      d.a_cdiv   = q.cdiv;
      d.cfg_err  = ~cfg_ok;
      d.pfd_cnt  = 4'h0;
      d.lock_cnt = 4'h0;
      d.fb_seen  = 1'b0;
      d.per_ok   = 1'b0;
      d.valid    = 1'b0;
      d.lk       = pll_synth_pkg::LK_HELD;
    end else begin
      d.valid = ~q.cfg_err;
      if (ref_edge && !q.cfg_err) begin
        // detector rate is reference over N
        if (q.pfd_cnt + 4'h1 >= q.a_prediv) begin
          d.pfd_cnt  = 4'h0;
          d.pfd_tick = 1'b1;
        end else begin
          d.pfd_cnt = q.pfd_cnt + 4'h1;
        end
      end
      unique case (q.lk)
        pll_synth_pkg::LK_HELD: begin
          d.lk = pll_synth_pkg::LK_ACQUIRE;
          if (q.cfg_err)
            ev[pll_synth_pkg::IRQ_CFG] = 1'b1;
        end
        pll_synth_pkg::LK_ACQUIRE: begin
          if (mismatch) begin
            d.lock_cnt = 4'h0;
          end else if (q.pfd_tick && !q.cfg_err) begin
            // fabric feedback must be toggling to count toward lock
            d.fb_seen = fb_edge;
            if (q.a_fb == 2'(pll_synth_pkg::FB_FABRIC) && !q.fb_seen) begin
              d.lock_cnt = 4'h0;
            end else if (q.lock_cnt + 4'h1 >= pll_synth_pkg::LOCK_PFD) begin
              d.lk = pll_synth_pkg::LK_LOCKED;
              ev[pll_synth_pkg::IRQ_GAINED] = 1'b1;
            end else begin
              d.lock_cnt = q.lock_cnt + 4'h1;
            end
          end
        end
        pll_synth_pkg::LK_LOCKED: begin
          // a stopped reference leaves the state alone
          if (mismatch || fb_lost) begin
            d.lk       = pll_synth_pkg::LK_ACQUIRE;
            d.lock_cnt = 4'h0;
            d.fb_seen  = 1'b0;
            ev[pll_synth_pkg::IRQ_LOST] = 1'b1;
          end
        end
      endcase
    end

    // sticky events, a set in the clearing cycle wins
    d.irq_stat = d.irq_stat | ev;

    // read data stands in the cycle after the strobe
    if (rd_in) begin
      unique case (addr_in)
        pll_synth_pkg::A_CTRL: begin
          d.rdata[pll_synth_pkg::CTRL_FB_LSB +: 2] = q.fb_mode;
          d.rdata[pll_synth_pkg::CTRL_EN_LSB +: 3] = q.out_en;
        end
        pll_synth_pkg::A_MULT:    d.rdata[7:0] = q.mult;
        pll_synth_pkg::A_PREDIV:  d.rdata[3:0] = q.prediv;
        pll_synth_pkg::A_POSTDIV: d.rdata[1:0] = q.postdiv;
        pll_synth_pkg::A_DIV0:    d.rdata[7:0] = q.cdiv[0];
        pll_synth_pkg::A_DIV1:    d.rdata[7:0] = q.cdiv[1];
        pll_synth_pkg::A_DIV2:    d.rdata[7:0] = q.cdiv[2];
        pll_synth_pkg::A_STATUS: begin
          d.rdata[pll_synth_pkg::ST_LOCKED] =
            q.lk == pll_synth_pkg::LK_LOCKED;
          d.rdata[pll_synth_pkg::ST_CFG_ERR] = q.cfg_err;
          d.rdata[pll_synth_pkg::ST_STALLED] = stalled;
          d.rdata[pll_synth_pkg::ST_HELD]    = held;
        end
        pll_synth_pkg::A_IRQ_STAT: d.rdata[2:0] = q.irq_stat;
        pll_synth_pkg::A_IRQ_MASK: d.rdata[2:0] = q.irq_mask;
        default: ;
      endcase
    end
  end

  // state register, settings return to their defaults on system reset
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      q          <= '0;
      q.fb_mode  <= pll_synth_pkg::RST_FB;
      q.out_en   <= pll_synth_pkg::RST_OUT_EN;
      q.mult     <= pll_synth_pkg::RST_MULT;
      q.prediv   <= pll_synth_pkg::RST_PREDIV;
      q.postdiv  <= pll_synth_pkg::RST_POSTDIV;
      q.cdiv     <= {3{pll_synth_pkg::RST_CDIV}};
      q.a_mult   <= pll_synth_pkg::RST_MULT;
      q.a_prediv <= pll_synth_pkg::RST_PREDIV;
      q.a_post   <= pll_synth_pkg::RST_POSTDIV;
      q.a_cdiv   <= {3{pll_synth_pkg::RST_CDIV}};
      q.lk       <= pll_synth_pkg::LK_HELD;
    end else begin
      q <= d;
    end
  end

  // three output channels sharing the detector tick
  logic [2:0] clk_k;
  for (genvar k = 0; k < 3; k++) begin : g_out
    synth_chan_if ch ();
    assign ch.pfd_tick   = q.pfd_tick;
    assign ch.run        = q.valid & q.a_en[k];
    assign ch.aligned    = q.a_fb != 2'(pll_synth_pkg::FB_INTERNAL);
    assign ch.skip_delay = q.a_fb == 2'(pll_synth_pkg::FB_FABRIC);
    assign ch.mult       = q.a_mult;
    assign ch.total      =
      12'(pll_synth_pkg::post_div_val(q.a_post)) *
      12'(cdiv_val(q.a_cdiv[k]));
    assign clk_k[k]      = ch.clk;

    synth_out_channel u_chan (
      .ref_clk_in (ref_clk_in),
      .srst_in    (srst_in),
      .ch         (ch)
    );
  end

  // outputs: clocks, valid and read data straight from flip-flops, lock and irq decoded from them
  assign synth_clock_out_0 = clk_k[0];
  assign synth_clock_out_1 = clk_k[1];
  assign synth_clock_out_2 = clk_k[2];
  assign clocks_valid_out  = q.valid;
  assign locked_out        = q.lk == pll_synth_pkg::LK_LOCKED;
  assign rdata_out         = q.rdata;
  assign irq_out           = |(q.irq_stat & q.irq_mask);
endmodule

// *** dv/pll_ref_source.sv ***
// pll_ref_source: four reference clocks and the fabric feedback loop.
// Assumes the bench stops or slows the references around whole periods.
module pll_ref_source (
  input  wire logic [3:0] stop_in,
  input  wire logic       slow_in,
  input  wire logic       out0_in,
  output logic      [3:0] refs_out,
  output logic            fb_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // 800 ns references, 1600 ns when slowed; a stopped one stands low
  // the slowed period differs by more than the tolerance from any phase
  for (genvar k = 0; k < 4; k++) begin : g_ref
    initial begin
      refs_out[k] = 1'b0;
      #(50 * k + 20);
      forever begin
        #(slow_in ? 800 : 400);
        refs_out[k] = stop_in[k] ? 1'b0 : ~refs_out[k];
      end
    end
  end

  // feedback pin tied to output clock 0
  assign fb_out = out0_in;
endmodule

// *** dv/pll_synth_checker.sv ***
// pll_synth_checker: port level checks of the synthesizer control block.
// Assumes the bind below attaches it to every instance of the block.
module pll_synth_checker #(
  parameter int unsigned DW = 16
) (
  input wire logic          ref_clk_in,
  input wire logic          srst_in,
  input wire logic [3:0]    reference_clock_inputs_in,
  input wire logic [1:0]    reference_source_select_in,
  input wire logic          synth_reset_low_in,
  input wire logic [3:0]    addr_in,
  input wire logic          rd_in,
  input wire logic [DW-1:0] rdata_out,
  input wire logic          synth_clock_out_0,
  input wire logic          synth_clock_out_1,
  input wire logic          synth_clock_out_2,
  input wire logic          clocks_valid_out,
  input wire logic          locked_out,
  input wire logic          irq_out
);
  logic       sel_ref;
  logic       prev_q;
  logic [7:0] gap_q;
  logic [7:0] hi_q;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  // cycles since the selected reference moved, and since release
  assign sel_ref = reference_clock_inputs_in[reference_source_select_in];
  always_ff @(posedge ref_clk_in) begin
    prev_q <= sel_ref;
    if (srst_in || sel_ref != prev_q) gap_q <= 8'h00;
    else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
    if (srst_in || !synth_reset_low_in) hi_q <= 8'h00;
    else if (hi_q != 8'hFF) hi_q <= hi_q + 8'h01;
  end

  // held, then released
  sequence seq_held;
    !synth_reset_low_in [*4];
  endsequence
  sequence seq_run;
    synth_reset_low_in [*6];
  endsequence

  AST_RST_OUTS: assert property (@(posedge ref_clk_in) disable iff (1'b0)
    srst_in |=> !locked_out && !clocks_valid_out && !irq_out
    && rdata_out == '0 && !synth_clock_out_0)
    else $error("outputs not cleared by system reset");
  AST_HELD_LOCK: assert property (
    seq_held |=> !locked_out && !clocks_valid_out)
    else $error("lock or valid high while held");
  AST_EARLY_LOCK: assert property (
    seq_held ##1 seq_run |-> !locked_out)
    else $error("lock too soon after release");
  AST_HELD_CLKS: assert property (
    !clocks_valid_out [*2] |-> !locked_out)
    else $error("locked while clocks invalid");
  AST_CLK_IDLE: assert property (
    !clocks_valid_out [*2] |->
    !synth_clock_out_0 && !synth_clock_out_1 && !synth_clock_out_2)
    else $error("clock runs while invalid");
  AST_LOCK_VALID: assert property (
    $rose(locked_out) |-> clocks_valid_out)
    else $error("lock without valid clocks");
  AST_STALL_HOLD: assert property (
    gap_q > 8'h14 && hi_q > 8'h08 |=> $stable(locked_out))
    else $error("lock changed while reference stalled");
  AST_RDATA_IDLE: assert property (
    !rd_in |=> rdata_out == '0)
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property (
    rd_in && addr_in >= 4'hA |=> rdata_out == '0)
    else $error("unmapped read not zero");
endmodule

bind pll_clock_synthesizer_ctrl pll_synth_checker #(.DW(DW)) chk_i (
  .ref_clk_in                 (ref_clk_in),
  .srst_in                    (srst_in),
  .reference_clock_inputs_in  (reference_clock_inputs_in),
  .reference_source_select_in (reference_source_select_in),
  .synth_reset_low_in         (synth_reset_low_in),
  .addr_in                    (addr_in),
  .rd_in                      (rd_in),
  .rdata_out                  (rdata_out),
  .synth_clock_out_0          (synth_clock_out_0),
  .synth_clock_out_1          (synth_clock_out_1),
  .synth_clock_out_2          (synth_clock_out_2),
  .clocks_valid_out           (clocks_valid_out),
  .locked_out                 (locked_out),
  .irq_out                    (irq_out)
);

// *** dv/tb.sv ***
// tb: settings table, lock, stall, loss, select and reset tests.
// Assumes the reference model sits on the far side of the block.
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  err_total++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [1:0] fb;
    logic [2:0] en;
    logic [7:0] m;
    logic [3:0] n;
    logic [1:0] oc;
    logic [7:0] cm1;
    int         per;
  } row_t;
  logic        ref_clk, srst, rst_low, fb, wr, rd, slow, valid, locked, irq;
  logic [3:0]  refs, stop, addr;
  logic [1:0]  sel;
  logic [15:0] wdata, rdata;
  logic [2:0]  outs;
  int          err_total, total_checks, p;
  // mode, enables, M, N, O code, C-1, expected output period in cycles
  row_t rows [9] = '{
    '{2'h1, 3'h1, 8'h80, 4'h1, 2'h1, 8'h01, 0},
    '{2'h0, 3'h3, 8'h01, 4'h1, 2'h0, 8'h01, 0},
    '{2'h3, 3'h1, 8'h01, 4'h1, 2'h1, 8'h01, 0},
    '{2'h0, 3'h1, 8'h01, 4'h0, 2'h1, 8'h01, 0},
    '{2'h1, 3'h1, 8'h01, 4'h1, 2'h2, 8'h01, 64},
    '{2'h2, 3'h1, 8'h04, 4'h1, 2'h1, 8'h01, 8},
    '{2'h0, 3'h1, 8'h01, 4'h2, 2'h1, 8'h01, 64},
    '{2'h0, 3'h7, 8'h02, 4'h1, 2'h1, 8'h01, 16},
    '{2'h0, 3'h1, 8'h01, 4'h1, 2'h1, 8'h01, 32}
  };
  logic [15:0] rst_val [7] = '{16'h0004, 16'h0001, 16'h0001, 16'h0001,
                               16'h0001, 16'h0001, 16'h0001};

  pll_clock_synthesizer_ctrl pll_clock_synthesizer_ctrl_i (
    .ref_clk_in                 (ref_clk),
    .srst_in                    (srst),
    .reference_clock_inputs_in  (refs),
    .reference_source_select_in (sel),
    .synth_reset_low_in         (rst_low),
    .fabric_feedback_clock_in   (fb),
    .addr_in                    (addr),
    .wdata_in                   (wdata),
    .wr_in                      (wr),
    .rd_in                      (rd),
    .rdata_out                  (rdata),
    .synth_clock_out_0          (outs[0]),
    .synth_clock_out_1          (outs[1]),
    .synth_clock_out_2          (outs[2]),
    .clocks_valid_out           (valid),
    .locked_out                 (locked),
    .irq_out                    (irq)
  );
  pll_ref_source pll_ref_source_i (
    .stop_in  (stop),
    .slow_in  (slow),
    .out0_in  (outs[0]),
    .refs_out (refs),
    .fb_out   (fb)
  );

  // 10 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(rdata, e)
  endtask
  task automatic wait_lk(input logic v);
    int k;
    k = 0;
    while (locked !== v && k < 800) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 800) begin
      err_total++;
      results();
    end
  endtask
  // rising edge to rising edge of one output, taken after it settles
  task automatic period(input int o, output int q);
    int n;
    int seen;
    logic prev;
    n = 0;
    seen = 0;
    q = 0;
    prev = outs[o];
    repeat (400) begin
      @(negedge ref_clk);
      n++;
      if (outs[o] === 1'b1 && prev === 1'b0) begin
        if (seen > 1 && q == 0) q = n;
        seen++;
        n = 0;
      end
      prev = outs[o];
    end
  endtask
  task automatic hold_reset(input logic [1:0] s);
    @(posedge ref_clk);
    rst_low <= 1'b0;
    tick(2);
    @(posedge ref_clk);
    sel <= s;
    tick(3);
    @(posedge ref_clk);
    rst_low <= 1'b1;
  endtask

  initial begin
    {srst, rst_low, wr, rd, slow, sel, stop, addr, wdata} = 'h0;
    srst = 1'b1;
    err_total = 0;
    total_checks = 0;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    // defaults, then unmapped places
    for (int a = 0; a < 7; a++) rreg(4'(a), rst_val[a]);
    rreg(4'hA, 16'h0000);
    rreg(4'hF, 16'h0000);
    wreg(pll_synth_pkg::A_IRQ_MASK, 16'h0007);
    foreach (rows[i]) begin
      @(posedge ref_clk);
      rst_low <= 1'b0;
      wreg(pll_synth_pkg::A_CTRL, {11'h000, rows[i].en, rows[i].fb});
      wreg(pll_synth_pkg::A_MULT, {8'h00, rows[i].m});
      wreg(pll_synth_pkg::A_PREDIV, {12'h000, rows[i].n});
      wreg(pll_synth_pkg::A_POSTDIV, {14'h0000, rows[i].oc});
      for (int d = 0; d < 3; d++)
        wreg(pll_synth_pkg::A_DIV0 + 4'(d), {8'h00, rows[i].cm1});
      wreg(pll_synth_pkg::A_IRQ_STAT, 16'h0007);
      tick(2);
      `CHK(irq, 1'b0)
      @(posedge ref_clk);
      rst_low <= 1'b1;
      if (rows[i].per > 0) begin
        wait_lk(1'b1);
        period(rows[i].en[2] ? 2 : 0, p);
        `CHK(p, rows[i].per)
        if (rows[i].en[1]) begin
          period(1, p);
          `CHK(p, rows[i].per)
        end
        rreg(pll_synth_pkg::A_IRQ_STAT, 16'h0001);
      end else begin
        tick(100);
        `CHK({valid, locked}, 2'b00)
        rreg(pll_synth_pkg::A_IRQ_STAT, 16'h0004);
      end
      `CHK(irq, 1'b1)
    end
    // reference stops and resumes while locked
    @(posedge ref_clk);
    stop <= 4'h1;
    tick(150);
    `CHK(locked, 1'b1)
    rreg(pll_synth_pkg::A_STATUS, 16'h0005);
    @(posedge ref_clk);
    stop <= 4'h0;
    tick(100);
    `CHK(locked, 1'b1)
    // period jump drops lock, interrupt masked then unmasked
    wreg(pll_synth_pkg::A_IRQ_MASK, 16'h0000);
    wreg(pll_synth_pkg::A_IRQ_STAT, 16'h0007);
    slow <= 1'b1;
    wait_lk(1'b0);
    rreg(pll_synth_pkg::A_IRQ_STAT, 16'h0002);
    `CHK(irq, 1'b0)
    wreg(pll_synth_pkg::A_IRQ_MASK, 16'h0002);
    tick(2);
    `CHK(irq, 1'b1)
    @(posedge ref_clk);
    slow <= 1'b0;
    // select a stopped reference, then a running one
    stop <= 4'h4;
    hold_reset(2'h2);
    tick(150);
    `CHK(locked, 1'b0)
    hold_reset(2'h1);
    wait_lk(1'b1);
    `CHK(locked, 1'b1)
    // synthesizer reset drops lock and clocks
    @(posedge ref_clk);
    rst_low <= 1'b0;
    tick(6);
    `CHK({valid, locked, outs}, 5'h00)
    // system reset mid-run restores defaults
    wreg(pll_synth_pkg::A_MULT, 16'h0005);
    srst <= 1'b1;
    tick(2);
    `CHK({valid, locked, irq}, 3'h0)
    @(posedge ref_clk);
    srst <= 1'b0;
    rreg(pll_synth_pkg::A_MULT, 16'h0001);
    results();
  end
endmodule
